// file: pmss_pkg.sv
// How it works
// [R1] host drives reference clock at baud/64
// [R2] config byte 1 bit 0 selects retiming
// [R3] bit low: recovered mode, refclk frequency only
// [R4] retiming clock must be exact baud/64
// [R5] retiming mode flags transmit retime ticks
// [R6] bus follows fast mode two-wire timing
// [R7] host sets select level before transactions
// [R8] select setup at least two milliseconds; the host model waits 200 cycles (4 us)
// [R9] host holds select until transaction done
// [R10] host waits ten microseconds before reselecting
// [R11] deselect mid-sequence releases SCL and SDA
// [R12] slave answers only at address 1010000
// [R13] select input defaults to deselected, pulled high
// [R14] host drives select low whole exchange
// [R15] deselected module never acknowledges nor acts
// [R16] multi-bit fields travel msb first
package pmss_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int DESEL_ABORT_MS = 2;
  localparam int DESEL_ABORT_CYC = DESEL_ABORT_MS * (CLK_HZ / 1000);
  localparam int SEL_SETUP_MS = 2;
  localparam int SEL_HOLD_US = 10;
  localparam logic [6:0] SLAVE_ADDR = 7'h50;
  localparam logic [7:0] CFG_BYTE = 8'h01;
  localparam int RETIME_BIT = 0;
  localparam int MEM_DEPTH = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] MEM_RST = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_WR = 6'h08,
    ST_RD = 6'h10,
    ST_RACK = 6'h20
  } pmss_state_t;

  typedef struct packed {
    logic unsel_n;
    logic refclk;
    logic sda;
    logic scl;
  } pmss_pins_t;

  // deselected, idle bus levels
  localparam pmss_pins_t PINS_RST = 4'hf;
endpackage

module pmss_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire pmss_pkg::pmss_pins_t d,
  output pmss_pkg::pmss_pins_t q
);
  pmss_pkg::pmss_pins_t meta_reg;
  pmss_pkg::pmss_pins_t q_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= pmss_pkg::PINS_RST;
      q_reg <= pmss_pkg::PINS_RST;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // pmss_sync

// file: pmss_top.sv
module pmss_top #(
  parameter int ABORT_CYC = pmss_pkg::DESEL_ABORT_CYC,
  parameter int MEM_DEPTH = pmss_pkg::MEM_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic module_unselect_line_n,
  input wire logic host_refclk,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic select_pullup_en,
  output logic synchronous_retime_clock_mode,
  output logic recovered_clock_mode,
  output logic refclk_tick,
  output logic retime_tick
);
  pmss_pkg::pmss_pins_t pins_raw;
  pmss_pkg::pmss_pins_t pins_s;
  pmss_pkg::pmss_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic first_reg, first_next;
  logic ack_reg, ack_next;
  logic oe_reg, oe_next;
  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] mem_next [MEM_DEPTH];
  logic scl_prev_reg, sda_prev_reg, ref_prev_reg;
  logic mode_reg, mode_next;
  logic recov_reg, recov_next;
  logic ref_tick_reg, ref_tick_next;
  logic rt_tick_reg, rt_tick_next;
  logic pullup_reg;
  logic low_reg;
  logic selected, start, stop, rise, fall, ref_rise;
  logic [7:0] rd_byte;

  assign pins_raw = '{unsel_n: module_unselect_line_n, refclk: host_refclk, sda: sda_in, scl: scl_in};

  // every pin crosses two flops before the slave logic looks at it
  pmss_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  assign selected = !pins_s.unsel_n;
  assign start = pins_s.scl && scl_prev_reg && sda_prev_reg && !pins_s.sda;
  assign stop = pins_s.scl && scl_prev_reg && !sda_prev_reg && pins_s.sda;
  assign rise = pins_s.scl && !scl_prev_reg;
  assign fall = !pins_s.scl && scl_prev_reg;
  assign ref_rise = pins_s.refclk && !ref_prev_reg;
  assign rd_byte = (ptr_reg < 8'(MEM_DEPTH)) ? mem_reg[ptr_reg[$clog2(MEM_DEPTH)-1:0]] : pmss_pkg::MEM_RST;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    ack_next = ack_reg;
    oe_next = oe_reg;
    mem_next = mem_reg;
    if (!selected) begin
      // dropping select aborts at once, so SDA lets go long before the deadline
      st_next = pmss_pkg::ST_IDLE; // [R15] [R11]
      oe_next = 1'h0;
    end else if (start) begin
      st_next = pmss_pkg::ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'h0;
    end else if (stop) begin
      st_next = pmss_pkg::ST_IDLE;
      oe_next = 1'h0;
    end else begin
      case (st_reg)
        pmss_pkg::ST_ADDR, pmss_pkg::ST_WR: begin
          if (rise && cnt_reg < pmss_pkg::BYTE_BITS) begin
            sh_next = {sh_reg[6:0], pins_s.sda}; // [R16]
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == pmss_pkg::BYTE_BITS) begin
            if (st_reg == pmss_pkg::ST_ADDR) begin
              if (sh_reg[7:1] == pmss_pkg::SLAVE_ADDR) begin // [R12]
                st_next = pmss_pkg::ST_ACK;
                oe_next = 1'h1;
                rw_next = sh_reg[0];
                first_next = !sh_reg[0];
              end else begin
                st_next = pmss_pkg::ST_IDLE;
              end
            end else begin
              if (first_reg) begin
                ptr_next = sh_reg;
                first_next = 1'h0;
              end else begin
                // writes past the implemented bytes are acknowledged and dropped
                if (ptr_reg < 8'(MEM_DEPTH)) begin
                  mem_next[ptr_reg[$clog2(MEM_DEPTH)-1:0]] = sh_reg; // [R2]
                end
                ptr_next = ptr_reg + 8'h01;
              end
              st_next = pmss_pkg::ST_ACK;
              oe_next = 1'h1;
            end
          end
        end
        pmss_pkg::ST_ACK: begin
          if (fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              sh_next = rd_byte;
              ptr_next = ptr_reg + 8'h01;
              oe_next = !rd_byte[7]; // [R16]
              st_next = pmss_pkg::ST_RD;
            end else begin
              oe_next = 1'h0;
              st_next = pmss_pkg::ST_WR;
            end
          end
        end
        pmss_pkg::ST_RD: begin
          if (rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall) begin
            if (cnt_reg == pmss_pkg::BYTE_BITS) begin
              oe_next = 1'h0;
              st_next = pmss_pkg::ST_RACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'h0};
              oe_next = !sh_reg[6]; // [R16]
            end
          end
        end
        pmss_pkg::ST_RACK: begin
          if (rise) begin
            ack_next = !pins_s.sda;
          end else if (fall) begin
            if (ack_reg) begin
              cnt_next = 4'h0;
              sh_next = rd_byte;
              ptr_next = ptr_reg + 8'h01;
              oe_next = !rd_byte[7];
              st_next = pmss_pkg::ST_RD;
            end else begin
              st_next = pmss_pkg::ST_IDLE;
            end
          end
        end
        pmss_pkg::ST_IDLE: begin
          oe_next = 1'h0;
        end
        default: begin
          st_next = pmss_pkg::ST_IDLE;
          oe_next = 1'h0;
        end
      endcase
    end
  end

  always_comb begin
    mode_next = mem_reg[pmss_pkg::CFG_BYTE[$clog2(MEM_DEPTH)-1:0]][pmss_pkg::RETIME_BIT]; // [R2]
    recov_next = !mode_next; // [R3]
    ref_tick_next = ref_rise && !mode_reg; // [R3]
    rt_tick_next = ref_rise && mode_reg; // [R5]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= pmss_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'h0;
      first_reg <= 1'h0;
      ack_reg <= 1'h0;
      oe_reg <= 1'h0;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_reg[i] <= pmss_pkg::MEM_RST;
      end
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
      ref_prev_reg <= 1'h1; // matches the synced reset level, so no false tick
      mode_reg <= 1'h0;
      recov_reg <= 1'h1;
      ref_tick_reg <= 1'h0;
      rt_tick_reg <= 1'h0;
      pullup_reg <= 1'h1;
      low_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      ack_reg <= ack_next;
      oe_reg <= oe_next;
      mem_reg <= mem_next;
      scl_prev_reg <= pins_s.scl;
      sda_prev_reg <= pins_s.sda;
      ref_prev_reg <= pins_s.refclk;
      mode_reg <= mode_next;
      recov_reg <= recov_next;
      ref_tick_reg <= ref_tick_next;
      rt_tick_reg <= rt_tick_next;
      pullup_reg <= 1'h1; // [R13]
      low_reg <= 1'h0;
    end
  end

  assign sda_out = low_reg;
  assign sda_oe = oe_reg;
  // no clock stretching, SCL is never driven
  assign scl_out = low_reg;
  assign scl_oe = low_reg; // [R6] [R11]
  assign select_pullup_en = pullup_reg;
  assign synchronous_retime_clock_mode = mode_reg;
  assign recovered_clock_mode = recov_reg;
  assign refclk_tick = ref_tick_reg;
  assign retime_tick = rt_tick_reg;

  logic [31:0] abort_cnt_reg, abort_cnt_next;
  assign abort_cnt_next = (selected || !oe_reg) ? 32'h0 : abort_cnt_reg + 32'h1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      abort_cnt_reg <= 32'h0;
    end else begin
      abort_cnt_reg <= abort_cnt_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_mode_follows_bit;
    $rose(mem_reg[pmss_pkg::CFG_BYTE[$clog2(MEM_DEPTH)-1:0]][pmss_pkg::RETIME_BIT]) |=> mode_reg ##1 mode_reg;
  endproperty
  a_mode_follows_bit: assert property (p_mode_follows_bit) else $error("retime mode did not follow config bit"); // [R2]
  property p_recov_default;
    !mode_reg && $stable(mode_reg) |-> recov_reg && !rt_tick_reg;
  endproperty
  a_recov_default: assert property (p_recov_default) else $error("recovered mode not held while bit low"); // [R3]
  property p_retime_tick;
    rt_tick_reg |-> $past(mode_reg) && !ref_tick_reg;
  endproperty
  a_retime_tick: assert property (p_retime_tick) else $error("retime tick outside retime mode"); // [R5]
  property p_no_stretch;
    !scl_oe;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("SCL driven by slave"); // [R6]
  property p_abort_release;
    $fell(selected) |-> ##[0:2] !sda_oe;
  endproperty
  a_abort_release: assert property (p_abort_release) else $error("SDA not released after deselect"); // [R11]
  property p_abort_deadline;
    abort_cnt_reg < 32'(ABORT_CYC);
  endproperty
  a_abort_deadline: assert property (p_abort_deadline) else $error("deselect abort deadline exceeded"); // [R11]
  property p_addr_match;
    st_reg == pmss_pkg::ST_ADDR && selected && !start && !stop && fall && cnt_reg == pmss_pkg::BYTE_BITS
      |=> sda_oe == (sh_reg[7:1] == pmss_pkg::SLAVE_ADDR);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("address acknowledge wrong"); // [R12]
  property p_pullup;
    ##1 select_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("select pull-up not enabled"); // [R13]
  property p_desel_quiet;
    !selected [*2] |-> !sda_oe && st_reg == pmss_pkg::ST_IDLE;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("deselected module active on bus"); // [R15]
  property p_msb_first;
    $rose(st_reg == pmss_pkg::ST_RD) |-> sda_oe == !sh_reg[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read byte not msb first"); // [R16]
  property p_cov_write;
    st_reg == pmss_pkg::ST_WR ##1 st_reg == pmss_pkg::ST_ACK;
  endproperty
  c_cov_write: cover property (p_cov_write);
  property p_cov_read;
    st_reg == pmss_pkg::ST_RACK ##1 st_reg == pmss_pkg::ST_RD;
  endproperty
  c_cov_read: cover property (p_cov_read);
  property p_cov_abort;
    oe_reg ##1 !selected;
  endproperty
  c_cov_abort: cover property (p_cov_abort);
  property p_cov_retime;
    $rose(retime_tick);
  endproperty
  c_cov_retime: cover property (p_cov_retime);
endmodule // pmss_top

// file: pmss_host_model.sv
module pmss_host_model #(
  parameter int LOW_CYC = 70,
  parameter int HIGH_CYC = 60,
  parameter int SETUP_CYC = 200
) (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  output logic unsel_n,
  output logic refclk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  logic sel_drv = 1'b0;
  // open drain with pull-ups: a released line reads high
  // the slave never stretches the clock, so only the host pulls scl
  assign scl = !scl_low;
  assign sda = !(sda_low || sda_oe);
  // undriven select floats to deselected
  assign unsel_n = !sel_drv;
  // exact 160 ns, free running, phase unrelated to clk
  initial begin
    refclk = 1'b0;
    #7;
    forever #80 refclk = ~refclk;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // setup scaled down from 2 ms to keep the run short
  task automatic select(input logic on);
    wait_n(500);
    sel_drv <= on;
    wait_n(SETUP_CYC);
  endtask
  task automatic abort();
    @(posedge clk);
    sel_drv <= 1'b0;
  endtask
  // scl low 1.5 us, high 1.2 us: under 400 kHz
  task automatic bit_io(input logic b, output logic r);
    wait_n(5);
    sda_low <= !b;
    wait_n(LOW_CYC);
    scl_low <= 1'b0;
    wait_n(HIGH_CYC);
    r = sda;
    scl_low <= 1'b1;
  endtask
  task automatic start();
    wait_n(5);
    sda_low <= 1'b0;
    wait_n(LOW_CYC);
    scl_low <= 1'b0;
    wait_n(HIGH_CYC);
    sda_low <= 1'b1;
    wait_n(HIGH_CYC);
    scl_low <= 1'b1;
  endtask
  task automatic stop();
    wait_n(5);
    sda_low <= 1'b1;
    wait_n(LOW_CYC);
    scl_low <= 1'b0;
    wait_n(HIGH_CYC);
    sda_low <= 1'b0;
    wait_n(1000);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule // pmss_host_model

// file: pmss_bench.sv
module pmss_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, scl, sda, unsel_n, refclk;
  logic scl_out, scl_oe, sda_out, sda_oe, pullup_en, retime, recovered, refclk_tick, retime_tick;
  int err_count = 0;
  int tests_run = 0;
  int n_ref = 0;
  int n_rt = 0;
  logic [7:0] q;
  logic [2:0] k;

  pmss_top #(.ABORT_CYC(50)) i_pmss_top (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .module_unselect_line_n(unsel_n), .host_refclk(refclk), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_pullup_en(pullup_en),
    .synchronous_retime_clock_mode(retime), .recovered_clock_mode(recovered),
    .refclk_tick(refclk_tick), .retime_tick(retime_tick));
  pmss_host_model i_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .unsel_n(unsel_n), .refclk(refclk));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    n_ref <= n_ref + int'(refclk_tick);
    n_rt <= n_rt + int'(retime_tick);
  end

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: bit got %b", $time, got);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: byte got %h", $time, got);
    end
  endtask
  task automatic write3(input logic [7:0] a, input logic [7:0] p, input logic [7:0] v);
    i_host.start();
    i_host.byte_io(a, 1'b1, q, k[2]);
    i_host.byte_io(p, 1'b1, q, k[1]);
    i_host.byte_io(v, 1'b1, q, k[0]);
    i_host.stop();
  endtask
  // tick counts over 100 cycles, about 12 refclk edges
  task automatic check_ticks(input logic want_rt);
    int r0, t0;
    r0 = n_ref;
    t0 = n_rt;
    repeat (100) @(posedge clk);
    check_bit(n_rt > t0, want_rt);
    check_bit(n_ref > r0, !want_rt);
  endtask

  task automatic t_reset();
    check_bit(pullup_en, 1'b1);
    check_bit(recovered, 1'b1);
    check_bit(retime, 1'b0);
    check_bit(sda_oe, 1'b0);
    check_bit(scl_oe, 1'b0);
    check_bit(sda_out, 1'b0);
    check_bit(scl_out, 1'b0);
  endtask
  task automatic t_retime_on();
    i_host.select(1'b1);
    write3(8'ha0, 8'h01, 8'h01);
    check_byte({5'h00, k}, 8'h00);
    check_bit(retime, 1'b1);
    check_bit(recovered, 1'b0);
    check_ticks(1'b1);
  endtask
  task automatic t_read_back();
    logic a;
    i_host.start();
    i_host.byte_io(8'ha0, 1'b1, q, a);
    i_host.byte_io(8'h01, 1'b1, q, a);
    i_host.start();
    i_host.byte_io(8'ha1, 1'b1, q, a);
    check_bit(a, 1'b0);
    // master ack asks for byte 2 as well, still at its reset value
    i_host.byte_io(8'hff, 1'b0, q, a);
    check_byte(q, 8'h01);
    i_host.byte_io(8'hff, 1'b1, q, a);
    check_byte(q, 8'h00);
    i_host.stop();
  endtask
  task automatic t_wrong_addr();
    write3(8'ha2, 8'h01, 8'h00);
    check_bit(k[2], 1'b1);
    check_bit(retime, 1'b1);
  endtask
  task automatic t_deselected();
    i_host.select(1'b0);
    check_bit(unsel_n, 1'b1);
    write3(8'ha0, 8'h01, 8'h00);
    check_byte({5'h00, k}, 8'h07);
    check_bit(retime, 1'b1);
  endtask
  task automatic t_recovered();
    i_host.select(1'b1);
    write3(8'ha0, 8'h01, 8'h00);
    check_bit(retime, 1'b0);
    check_bit(recovered, 1'b1);
    check_ticks(1'b0);
  endtask
  // byte 2 reads 00, so the module holds sda low when cut off
  task automatic t_abort();
    logic a;
    i_host.start();
    i_host.byte_io(8'ha1, 1'b1, q, a);
    i_host.wait_n(70);
    check_bit(sda_oe, 1'b1);
    i_host.abort();
    i_host.wait_n(10);
    check_bit(sda_oe, 1'b0);
    check_bit(scl_oe, 1'b0);
    i_host.stop();
  endtask

  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_retime_on();
    t_read_back();
    t_wrong_addr();
    t_deselected();
    t_recovered();
    t_abort();
    results();
  end
  initial begin
    // traffic needs about 32k cycles; 50k cycles leaves margin
    #1000000;
    err_count++;
    results();
  end
endmodule // pmss_bench
